// File: logic/global_power_pkg.sv
// Purpose: constants for the global control and power register bank
// Assumes: 8-bit register port, byte offsets as printed
// Notes: timing counts derived from the 100 MHz clock
package global_power_pkg;
   localparam logic [7:0] OFF_TEST_A = 8'h09;
   localparam logic [7:0] OFF_TEST_B = 8'h0a;
   localparam logic [7:0] OFF_EDGE_LED = 8'h0b;
   localparam logic [7:0] OFF_CPU_TAG = 8'h0c;
   localparam logic [7:0] OFF_TEST_C = 8'h0d;
   localparam logic [7:0] OFF_POWER = 8'h0e;
   localparam logic [7:0] OFF_SLEEP = 8'h0f;
   localparam logic [7:0] RST_TEST_A = 8'h40;
   localparam logic [7:0] RST_TEST_B = 8'h00;
   localparam logic [7:0] RST_TEST_C = 8'h00;
   localparam logic [7:0] RST_SLEEP = 8'h50;
   localparam logic [1:0] RST_CPU_CLK = 2'h1;
   localparam logic [1:0] RSVD_CTL10_HI = 2'h1;
   localparam logic [1:0] RSVD_CTL10_LO = 2'h1;
   localparam int BIT_RMII_EDGE = 6;
   localparam int BIT_LED_LO = 4;
   localparam int BIT_REFCLK = 1;
   localparam int BIT_SPI_EDGE = 0;
   localparam int BIT_CPU_CLK_LO = 4;
   localparam int BIT_TAIL_TAG = 1;
   localparam int BIT_PASS_PAUSE = 0;
   localparam int BIT_PLL_DOWN = 5;
   localparam int BIT_PMODE_LO = 3;
   localparam logic [1:0] PMODE_NORMAL = 2'h0;
   localparam logic [1:0] PMODE_ENERGY = 2'h1;
   localparam logic [1:0] PMODE_SOFT_DOWN = 2'h2;
   localparam logic [1:0] CPU_CLK_RESERVED = 2'h3;
   localparam int CLK_PERIOD_NS = 10;
   localparam int SLEEP_UNIT_MS = 20;
   localparam int SLEEP_UNIT_CYCLES = SLEEP_UNIT_MS * 1000000 / CLK_PERIOD_NS;
endpackage : global_power_pkg

// File: logic/switch_global_control_power_regs.sv
// Purpose: global control and power-management register bank
// Assumes: host reaches registers through a byte-wide register port
// Notes: read of the power register clears its mode field
//
// Behaviour
// - Bit 6 of 0x0b picks the uplink receive sampling edge, reset 0.
// - Bit 0 of register 0x0b picks the SPI read sampling edge.
// - Field 5:4 of 0x0c picks the internal clock; 01 at reset, 11 reserved.
// - Tail-tag bit set makes uplink egress frames carry one extra byte.
// - Pass-pause bit set forwards pause frames, clear filters them.
// - PLL power-down bit acts only while energy-detect mode is active.
// - Field 4:3 of 0x0e picks normal, energy-detect or soft power-down.
// - A host read of the power register clears the power mode field.
// - Energy-detect sleep waits the programmed count of 20 ms of no energy.
`timescale 1ns/100ps
module switch_global_control_power_regs
#(
   parameter int UNIT_CYCLES = global_power_pkg::SLEEP_UNIT_CYCLES
)
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic refclk_strap_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic energy_present_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   output logic rmii_sample_falling_o,
   output logic spi_sample_rising_o,
   output logic [1:0] port_led_mode_o,
   output logic reference_clock_output_en_o,
   output logic [1:0] cpu_clock_select_o,
   output logic tail_tag_en_o,
   output logic pass_pause_o,
   output logic [1:0] power_state_o,
   output logic pll_power_down_o,
   output logic low_power_o
);
   import global_power_pkg::*;

   // ==========================================================
   // register file
   // ==========================================================
   logic rmii_edge, next_rmii_edge;
   logic spi_edge, next_spi_edge;
   logic [1:0] led_mode, next_led_mode;
   logic refclk_en, next_refclk_en;
   logic strap_done, next_strap_done;
   logic [1:0] cpu_clk, next_cpu_clk;
   logic tail_tag, next_tail_tag;
   logic pass_pause, next_pass_pause;
   logic pll_down, next_pll_down;
   logic [1:0] pmode, next_pmode;
   logic [7:0] sleep_time, next_sleep_time;
   logic [7:0] rdata, next_rdata;
   logic rvalid, next_rvalid;

   always_comb
   begin
      next_rmii_edge = rmii_edge;
      next_spi_edge = spi_edge;
      next_led_mode = led_mode;
      next_refclk_en = refclk_en;
      next_strap_done = 1'b1;
      next_cpu_clk = cpu_clk;
      next_tail_tag = tail_tag;
      next_pass_pause = pass_pause;
      next_pll_down = pll_down;
      next_pmode = pmode;
      next_sleep_time = sleep_time;
      next_rvalid = reg_rd_i;
      next_rdata = 8'h00;
      if (!strap_done)
         next_refclk_en = refclk_strap_i;
      if (reg_rd_i)
      begin
         if (reg_addr_i == OFF_TEST_A)
            next_rdata = RST_TEST_A;
         else if (reg_addr_i == OFF_TEST_B)
            next_rdata = RST_TEST_B;
         else if (reg_addr_i == OFF_EDGE_LED)
         begin
            next_rdata[BIT_RMII_EDGE] = rmii_edge;
            next_rdata[BIT_LED_LO +: 2] = led_mode;
            next_rdata[BIT_REFCLK] = refclk_en;
            next_rdata[BIT_SPI_EDGE] = spi_edge;
         end
         else if (reg_addr_i == OFF_CPU_TAG)
         begin
            next_rdata[7:6] = RSVD_CTL10_HI;
            next_rdata[BIT_CPU_CLK_LO +: 2] = cpu_clk;
            next_rdata[3:2] = RSVD_CTL10_LO;
            next_rdata[BIT_TAIL_TAG] = tail_tag;
            next_rdata[BIT_PASS_PAUSE] = pass_pause;
         end
         else if (reg_addr_i == OFF_TEST_C)
            next_rdata = RST_TEST_C;
         else if (reg_addr_i == OFF_POWER)
         begin
            next_rdata[BIT_PLL_DOWN] = pll_down;
            next_rdata[BIT_PMODE_LO +: 2] = pmode;
            next_pmode = PMODE_NORMAL;
         end
         else if (reg_addr_i == OFF_SLEEP)
            next_rdata = sleep_time;
      end
      if (reg_wr_i)
      begin
         if (reg_addr_i == OFF_EDGE_LED)
         begin
            next_rmii_edge = reg_wdata_i[BIT_RMII_EDGE];
            next_led_mode = reg_wdata_i[BIT_LED_LO +: 2];
            next_refclk_en = reg_wdata_i[BIT_REFCLK];
            next_spi_edge = reg_wdata_i[BIT_SPI_EDGE];
         end
         else if (reg_addr_i == OFF_CPU_TAG)
         begin
            next_cpu_clk = reg_wdata_i[BIT_CPU_CLK_LO +: 2];
            next_tail_tag = reg_wdata_i[BIT_TAIL_TAG];
            next_pass_pause = reg_wdata_i[BIT_PASS_PAUSE];
         end
         else if (reg_addr_i == OFF_POWER)
         begin
            next_pll_down = reg_wdata_i[BIT_PLL_DOWN];
            next_pmode = reg_wdata_i[BIT_PMODE_LO +: 2];
         end
         else if (reg_addr_i == OFF_SLEEP)
            next_sleep_time = reg_wdata_i;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rmii_edge <= 1'b0;
         spi_edge <= 1'b0;
         led_mode <= 2'h0;
         refclk_en <= 1'b0;
         strap_done <= 1'b0;
         cpu_clk <= RST_CPU_CLK;
         tail_tag <= 1'b0;
         pass_pause <= 1'b0;
         pll_down <= 1'b0;
         pmode <= PMODE_NORMAL;
         sleep_time <= RST_SLEEP;
         rdata <= 8'h00;
         rvalid <= 1'b0;
      end
      else
      begin
         rmii_edge <= next_rmii_edge;
         spi_edge <= next_spi_edge;
         led_mode <= next_led_mode;
         refclk_en <= next_refclk_en;
         strap_done <= next_strap_done;
         cpu_clk <= next_cpu_clk;
         tail_tag <= next_tail_tag;
         pass_pause <= next_pass_pause;
         pll_down <= next_pll_down;
         pmode <= next_pmode;
         sleep_time <= next_sleep_time;
         rdata <= next_rdata;
         rvalid <= next_rvalid;
      end
   end

   // ==========================================================
   // energy-detect sleep timer
   // ==========================================================
   typedef enum logic [1:0] {PS_NORMAL, PS_WATCH, PS_SLEEP, PS_DOWN}
      pstate_t;
   pstate_t ps, next_ps;
   logic [31:0] unit_cnt, next_unit_cnt;
   logic [7:0] quiet_units, next_quiet_units;
   logic low_power, next_low_power;
   logic pll_off, next_pll_off;
   logic [1:0] power_state, next_power_state;

   always_comb
   begin
      next_ps = ps;
      next_unit_cnt = unit_cnt;
      next_quiet_units = quiet_units;
      case (ps)
         PS_NORMAL:
         begin
            next_unit_cnt = 32'h0000_0000;
            next_quiet_units = 8'h00;
            if (pmode == PMODE_ENERGY)
            begin
               next_ps = PS_WATCH;
            end
            else if (pmode == PMODE_SOFT_DOWN)
            begin
               next_ps = PS_DOWN;
            end
         end
         PS_WATCH:
         begin
            if (pmode != PMODE_ENERGY)
            begin
               next_ps = PS_NORMAL;
            end
            else if (energy_present_i)
            begin
               next_unit_cnt = 32'h0000_0000;
               next_quiet_units = 8'h00;
            end
            else if (quiet_units >= sleep_time)
            begin
               next_ps = PS_SLEEP;
            end
            else if (unit_cnt == 32'(UNIT_CYCLES - 1))
            begin
               next_unit_cnt = 32'h0000_0000;
               next_quiet_units = quiet_units + 8'h01;
            end
            else
            begin
               next_unit_cnt = unit_cnt + 32'h0000_0001;
            end
         end
         PS_SLEEP:
         begin
            if (pmode != PMODE_ENERGY || energy_present_i)
            begin
               next_ps = PS_NORMAL;
            end
         end
         default:
         begin
            if (pmode != PMODE_SOFT_DOWN)
            begin
               next_ps = PS_NORMAL;
            end
         end
      endcase
      next_low_power = (next_ps == PS_SLEEP) || (next_ps == PS_DOWN);
      next_pll_off = (next_ps == PS_SLEEP) && pll_down;
      next_power_state = (next_pmode == CPU_CLK_RESERVED) ? PMODE_NORMAL
         : next_pmode;
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ps <= PS_NORMAL;
         unit_cnt <= 32'h0000_0000;
         quiet_units <= 8'h00;
         low_power <= 1'b0;
         pll_off <= 1'b0;
         power_state <= PMODE_NORMAL;
      end
      else
      begin
         ps <= next_ps;
         unit_cnt <= next_unit_cnt;
         quiet_units <= next_quiet_units;
         low_power <= next_low_power;
         pll_off <= next_pll_off;
         power_state <= next_power_state;
      end
   end

   assign reg_rdata_o = rdata;
   assign reg_rvalid_o = rvalid;
   assign rmii_sample_falling_o = rmii_edge;
   assign spi_sample_rising_o = spi_edge;
   assign port_led_mode_o = led_mode;
   assign reference_clock_output_en_o = refclk_en;
   assign cpu_clock_select_o = cpu_clk;
   assign tail_tag_en_o = tail_tag;
   assign pass_pause_o = pass_pause;
   assign power_state_o = power_state;
   assign pll_power_down_o = pll_off;
   assign low_power_o = low_power;

   // ==========================================================
   // checks
   // ==========================================================
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   chk_edge_write: assert property (
      reg_wr_i && reg_addr_i == OFF_EDGE_LED |=>
      rmii_sample_falling_o == $past(reg_wdata_i[6]))
      else $error("uplink edge bit not written");
   chk_spi_write: assert property (
      reg_wr_i && reg_addr_i == OFF_EDGE_LED |=>
      spi_sample_rising_o == $past(reg_wdata_i[0]))
      else $error("spi edge bit not written");
   chk_clk_field: assert property (
      reg_wr_i && reg_addr_i == OFF_CPU_TAG |=>
      cpu_clock_select_o == $past(reg_wdata_i[5:4]))
      else $error("clock select not written");
   chk_tag_pause: assert property (
      reg_wr_i && reg_addr_i == OFF_CPU_TAG |=>
      tail_tag_en_o == $past(reg_wdata_i[1])
      && pass_pause_o == $past(reg_wdata_i[0]))
      else $error("tag or pause bit not written");
   chk_pause_hold: assert property (
      !(reg_wr_i && reg_addr_i == OFF_CPU_TAG) |=> $stable(pass_pause_o))
      else $error("pause bit changed without write");
   chk_pll_gate: assert property (
      pll_power_down_o |-> low_power_o && $past(pmode) == PMODE_ENERGY)
      else $error("pll down outside energy detect");
   chk_mode_write: assert property (
      reg_wr_i && reg_addr_i == OFF_POWER |=>
      pmode == $past(reg_wdata_i[4:3]))
      else $error("power mode not written");
   chk_read_clear: assert property (
      reg_rd_i && !reg_wr_i && reg_addr_i == OFF_POWER |=>
      pmode == PMODE_NORMAL && reg_rvalid_o)
      else $error("power mode not cleared by read");
   chk_sleep_wait: assert property (
      $rose(ps == PS_SLEEP) |-> $past(quiet_units) >= $past(sleep_time)
      && !$past(energy_present_i))
      else $error("sleep entered too early");
   chk_led_write: assert property (
      reg_wr_i && reg_addr_i == OFF_EDGE_LED |=>
      port_led_mode_o == $past(reg_wdata_i[5:4]))
      else $error("led mode not written");
   chk_refclk_write: assert property (
      reg_wr_i && reg_addr_i == OFF_EDGE_LED |=>
      reference_clock_output_en_o == $past(reg_wdata_i[1]))
      else $error("reference clock enable not written");
endmodule : switch_global_control_power_regs

// File: tb/host_model.sv
// Purpose: host side model issuing byte register reads and writes
// Assumes: one-cycle strobes, read answer one cycle after the read edge
// Notes: released address and data lines carry the inverse of last value
`timescale 1ns/100ps
module host_model
(
   input wire logic ref_clk_i,
   input wire logic [7:0] reg_rdata_i,
   input wire logic reg_rvalid_i,
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o
);
   // idle cycles before each access, set by the bench
   int unsigned slow = 0;

   initial
   begin
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
   end

   // =====================================================
   // access tasks
   // accesses paced by the register clock only
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      repeat (slow) @(posedge ref_clk_i);
      @(posedge ref_clk_i);
      reg_wr_o <= 1'b1;
      reg_addr_o <= a;
      reg_wdata_o <= d;
      @(posedge ref_clk_i);
      reg_wr_o <= 1'b0;
      reg_addr_o <= ~a;
      reg_wdata_o <= ~d;
   endtask : write

   task automatic read(input logic [7:0] a, output logic [7:0] d,
                       output logic v);
      repeat (slow) @(posedge ref_clk_i);
      @(posedge ref_clk_i);
      reg_rd_o <= 1'b1;
      reg_addr_o <= a;
      @(posedge ref_clk_i);
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~a;
      @(posedge ref_clk_i);
      d = reg_rdata_i;
      v = reg_rvalid_i;
   endtask : read
endmodule : host_model

// File: tb/switch_global_control_power_regs_bench.sv
// Purpose: self-checking bench for the global control and power bank
// Assumes: sleep unit shortened to a few clock cycles
// Notes: random register traffic with fixed seed plus power corner cases
`timescale 1ns/100ps
module switch_global_control_power_regs_bench;
   import global_power_pkg::*;
   localparam int UNIT = 4;
   // expected run is under 2000 cycles
   localparam int WATCH_NS = 200000;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic refclk_strap_i = 1'b1;
   logic energy_present_i = 1'b1;
   logic reg_wr_i, reg_rd_i, reg_rvalid_o, rmii_sample_falling_o;
   logic spi_sample_rising_o, reference_clock_output_en_o, tail_tag_en_o;
   logic pass_pause_o, pll_power_down_o, low_power_o;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
   logic [1:0] port_led_mode_o, cpu_clock_select_o, power_state_o;
   logic [7:0] shadow_b, shadow_c, shadow_f, a, d;
   int errors = 0;
   int tests_run = 0;
   int seed_dummy;

   always #5 ref_clk_i = ~ref_clk_i;

   switch_global_control_power_regs #(.UNIT_CYCLES(UNIT)) dut (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .refclk_strap_i(refclk_strap_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .energy_present_i(energy_present_i),
      .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
      .rmii_sample_falling_o(rmii_sample_falling_o),
      .spi_sample_rising_o(spi_sample_rising_o),
      .port_led_mode_o(port_led_mode_o),
      .reference_clock_output_en_o(reference_clock_output_en_o),
      .cpu_clock_select_o(cpu_clock_select_o), .tail_tag_en_o(tail_tag_en_o),
      .pass_pause_o(pass_pause_o), .power_state_o(power_state_o),
      .pll_power_down_o(pll_power_down_o), .low_power_o(low_power_o));

   host_model host (
      .ref_clk_i(ref_clk_i), .reg_rdata_i(reg_rdata_o),
      .reg_rvalid_i(reg_rvalid_o), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
      .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));

   // =====================================================
   // expectations and checks
   function automatic logic [7:0] expect_read(input logic [7:0] x);
      case (x)
         OFF_TEST_A: return RST_TEST_A;
         OFF_EDGE_LED: return shadow_b & 8'h73;
         OFF_CPU_TAG: return {RSVD_CTL10_HI, shadow_c[5:4], RSVD_CTL10_LO,
                              shadow_c[1:0]};
         OFF_SLEEP: return shadow_f;
         default: return 8'h00;
      endcase
   endfunction : expect_read

   task automatic check(input string what, input logic [7:0] e,
                        input logic [7:0] g);
      tests_run++;
      if (g !== e)
      begin
         errors++;
         $display("unexpected %s expected %h seen %h", what, e, g);
      end
   endtask : check

   task automatic read_check(input logic [7:0] x, input logic [7:0] e);
      logic [7:0] rd;
      logic v;
      host.read(x, rd, v);
      check("read valid", 8'h01, {7'h00, v});
      check("read data", e, rd);
   endtask : read_check

   task automatic check_outputs;
      check("edge led clock",
            {3'h0, shadow_b[6], shadow_b[5:4], shadow_b[1:0]},
            {3'h0, rmii_sample_falling_o, port_led_mode_o,
             reference_clock_output_en_o,
             spi_sample_rising_o});
      check("clock tag pause", {4'h0, shadow_c[5:4], shadow_c[1:0]},
            {4'h0, cpu_clock_select_o, tail_tag_en_o,
             pass_pause_o});
   endtask : check_outputs

   task automatic sleep_run(input logic pll);
      int n;
      n = 0;
      host.write(OFF_POWER, {2'b00, pll, PMODE_ENERGY, 3'b000});
      energy_present_i <= 1'b0;
      while (low_power_o !== 1'b1 && n < 60)
      begin
         @(posedge ref_clk_i);
         n++;
      end
      check("sleep delay", 8'h01,
            8'((n >= 3 * UNIT) && (n <= 3 * UNIT + 4)));
      check("pll down", {7'h00, pll}, {7'h00, pll_power_down_o});
      energy_present_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      check("wake", 8'h00, {6'h00, pll_power_down_o, low_power_o});
      read_check(OFF_POWER, {2'b00, pll, PMODE_ENERGY, 3'b000});
   endtask : sleep_run

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : conclude

   // =====================================================
   // tests
   initial
   begin
      seed_dummy = $urandom(41);
      repeat (8) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      shadow_b = 8'h02;
      shadow_c = {2'b00, RST_CPU_CLK, 4'h0};
      shadow_f = RST_SLEEP;
      check_outputs;
      check("power outputs", 8'h00, {4'h0, power_state_o, pll_power_down_o,
                                      low_power_o});
      for (int i = 8; i <= 16; i++)
         read_check(8'(i), expect_read(8'(i)));
      $display("test reset values done");

      for (int i = 0; i < 30; i++)
      begin
         a = OFF_TEST_A + 8'($urandom_range(6, 0));
         if (a == OFF_POWER)
            a = 8'h10;
         d = 8'($urandom);
         if (a == OFF_CPU_TAG && d[5:4] == CPU_CLK_RESERVED)
            d[4] = 1'b0;
         host.slow = $urandom_range(2, 0);
         host.write(a, d);
         @(posedge ref_clk_i);
         if (a == OFF_EDGE_LED)
            shadow_b = d;
         if (a == OFF_CPU_TAG)
            shadow_c = d;
         if (a == OFF_SLEEP)
            shadow_f = d;
         check_outputs;
         read_check(a, expect_read(a));
      end
      host.slow = 0;
      $display("test random access done");

      for (int m = 0; m < 4; m++)
      begin
         host.write(OFF_POWER, {3'b001, 2'(m), 3'b000});
         repeat (3) @(posedge ref_clk_i);
         check("mode", 8'(m % 3), {6'h00, power_state_o});
         check("low power", 8'(m == 2), {7'h00, low_power_o});
         check("pll awake", 8'h00, {7'h00, pll_power_down_o});
         read_check(OFF_POWER, {3'b001, 2'(m), 3'b000});
         @(posedge ref_clk_i);
         check("mode cleared", 8'h00, {6'h00, power_state_o});
         read_check(OFF_POWER, 8'h20);
      end
      $display("test power modes done");

      shadow_f = 8'h03;
      host.write(OFF_SLEEP, shadow_f);
      sleep_run(1'b1);
      sleep_run(1'b0);
      $display("test sleep done");

      // second reset with the strap low
      refclk_strap_i <= 1'b0;
      rst_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      shadow_b = 8'h00;
      shadow_c = {2'b00, RST_CPU_CLK, 4'h0};
      shadow_f = RST_SLEEP;
      check_outputs;
      check("power outputs", 8'h00, {4'h0, power_state_o, pll_power_down_o,
                                      low_power_o});
      read_check(OFF_SLEEP, expect_read(OFF_SLEEP));
      $display("test reset again done");
      conclude;
   end

   initial
   begin
      #(WATCH_NS);
      errors++;
      $display("watchdog expired");
      conclude;
   end
endmodule : switch_global_control_power_regs_bench
